// File: logic/cpmc_pkg.sv
// shared constants, types and states of the cpu power mode controller
// assumes one always-running clock pclk at 20 MHz and an APB register bus
//
// Function
// - halt with sleep select one enters sleep
// - halt with sleep select zero enters idle
// - normal clocks core and peripherals
// - idle stops core, keeps oscillator, peripherals
// - any enabled interrupt wakes idle
// - idle wake with global enable: service first
// - idle wake without global enable: resume directly
// - reset pin or watchdog time-out resets all
// - sleep switches the oscillator off
// - only wake pin (level or edge) or a reset source ends sleep
// - sleep wake waits a warm-up period
// - edge mode enters sleep with pin high
// - sleep ignores interrupts but records them
// - normal mode services enabled interrupts when global
package cpmc_pkg;

	// -------------------------------------------------------------------
	// register map, byte addresses
	// -------------------------------------------------------------------
	localparam logic [7:0] CPMC_MODE_CTRL_IDX = 8'h05;
	localparam logic [7:0] CPMC_MODE_CTRL_ADDR = 8'h14;
	localparam logic [7:0] CPMC_STATE_ADDR = 8'h00;
	localparam logic [7:0] CPMC_SRC_EN_ADDR = 8'h04;
	localparam logic [7:0] CPMC_PEND_ADDR = 8'h08;
	localparam logic [7:0] CPMC_EVT_ADDR = 8'h0c;
	localparam logic [7:0] CPMC_EVT_MASK_ADDR = 8'h10;

	// -------------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------------
	localparam int CPMC_WAKE_SENS_BIT = 0;
	localparam int CPMC_SLEEP_SEL_BIT = 1;
	localparam int CPMC_ONE_BIT = 2;
	localparam int CPMC_FIELD_LSB = 4;
	localparam logic [7:0] CPMC_MODE_CTRL_RST = 8'h00;
	localparam logic [7:0] CPMC_MODE_CTRL_WMASK = 8'h73;
	localparam int CPMC_EVT_IDLE_WAKE = 0;
	localparam int CPMC_EVT_SLEEP_WAKE = 1;
	localparam int CPMC_EVT_SLEEP_REQ = 2;
	localparam int CPMC_EVT_FULL_RESET = 3;
	localparam int CPMC_EVT_W = 4;

	// -------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------
	localparam int CPMC_CLK_HZ = 20_000_000;
	localparam int CPMC_WARMUP_CYCLES = 16;

	typedef enum logic [1:0] {
		CPMC_NORMAL,
		CPMC_IDLE,
		CPMC_SLEEP,
		CPMC_WARMUP
	} cpmc_state_t;

	// clock gating controls towards the clock tree
	typedef struct packed {
		logic osc_en;
		logic core_en;
		logic periph_en;
	} cpmc_clk_t;

endpackage

// File: logic/cpmc_wake_detect.sv
// sleep wake pin detector, level or rising-edge sensitive
// assumes the pin is synchronous to pclk and pclk never stops
`timescale 1ns/1ns
module cpmc_wake_detect
	import cpmc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic armed,
	input wire logic edge_mode,
	// pin and result
	input wire logic wake_pin,
	output logic wake
);

	logic pin_prev;

	// previous pin level for edge detection, kept running always
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= wake_pin;
		end
	end

	// only honoured while armed, runs on the always-on clock
	assign wake = armed && (edge_mode ? (wake_pin && !pin_prev) : wake_pin);

endmodule // cpmc_wake_detect

// File: logic/cpmc_warmup.sv
// oscillator warm-up timer
// assumes start is a one-cycle pulse; done pulses once after the period
`timescale 1ns/1ns
module cpmc_warmup
	import cpmc_pkg::*;
#(
	parameter int CYCLES = CPMC_WARMUP_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	// control
	input wire logic start,
	output logic done
);

	logic [15:0] count;
	logic running;

	// count the period down, pulse done in the cycle after the count reaches zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 16'h0000;
			running <= 1'b0;
			done <= 1'b0;
		end else if (clear) begin
			count <= 16'h0000;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= 16'(CYCLES - 1);
				running <= 1'b1;
			end else if (running) begin
				if (count == 16'h0000) begin
					running <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 16'h0001;
				end
			end
		end
	end

endmodule // cpmc_warmup

// File: logic/cpmc_top.sv
// cpu power mode controller: normal, idle and sleep with wake-up and reset
// assumes core signals and pins synchronous to pclk; APB slave without wait states
`timescale 1ns/1ns
module cpmc_top
	import cpmc_pkg::*;
#(
	parameter int PERIPH_W = 8,
	parameter int WARMUP = CPMC_WARMUP_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu core
	input wire logic halt_instruction,
	input wire logic global_irq_enable,
	input wire logic [PERIPH_W+1:0] irq_ack,
	output logic core_resume,
	output logic irq_service,
	// interrupt sources
	input wire logic [PERIPH_W-1:0] periph_irq,
	input wire logic wdt_irq,
	input wire logic ext_irq0_n,
	// reset sources and wake pin
	input wire logic reset_pin_n,
	input wire logic wdt_timeout,
	input wire logic sleep_wake_pin,
	// clock gating, reset and status
	output cpmc_clk_t clk_ctrl,
	output logic sys_reset,
	output cpmc_state_t mode,
	output logic irq
);

	localparam int SRC_W = PERIPH_W + 2;

	// -------------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------------
	cpmc_state_t state;
	cpmc_state_t next_state;
	logic [7:0] mode_ctrl;
	logic [SRC_W-1:0] src_en;
	logic [SRC_W-1:0] pend;
	logic [SRC_W-1:0] src_req;
	logic [CPMC_EVT_W-1:0] evt;
	logic [CPMC_EVT_W-1:0] evt_mask;
	logic [CPMC_EVT_W-1:0] evt_set;
	logic ext0_prev;
	logic full_reset;
	logic wake_pin_hit;
	logic warm_done;
	logic irq_hit;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic idle_wake;
	logic sleep_sel;
	logic wake_sens;
	logic [7:0] mode_ctrl_rd;

	assign sleep_sel = mode_ctrl[CPMC_SLEEP_SEL_BIT];
	assign wake_sens = mode_ctrl[CPMC_WAKE_SENS_BIT];
	assign full_reset = !reset_pin_n || wdt_timeout;

	// -------------------------------------------------------------------
	// interrupt request flags
	// -------------------------------------------------------------------

	// falling edge of the external interrupt pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext0_prev <= 1'b1;
		end else begin
			ext0_prev <= ext_irq0_n;
		end
	end

	assign src_req = {(ext0_prev && !ext_irq0_n), wdt_irq, periph_irq};

	// one sticky flag per source, set wins over the core's acknowledge
	generate
		for (genvar i = 0; i < SRC_W; i++) begin : g_pend
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend[i] <= 1'b0;
				end else if (full_reset) begin
					pend[i] <= 1'b0;
				end else if (src_req[i]) begin
					pend[i] <= 1'b1;
				end else if (irq_ack[i]) begin
					pend[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq_hit = |(pend & src_en);

	// -------------------------------------------------------------------
	// mode sequencing
	// -------------------------------------------------------------------
	cpmc_wake_detect u_wake (
		.pclk(pclk),
		.presetn(presetn),
		.armed(state == CPMC_SLEEP),
		.edge_mode(wake_sens),
		.wake_pin(sleep_wake_pin),
		.wake(wake_pin_hit)
	);

	cpmc_warmup #(
		.CYCLES(WARMUP)
	) u_warm (
		.pclk(pclk),
		.presetn(presetn),
		.clear(full_reset),
		.start(state == CPMC_SLEEP && wake_pin_hit),
		.done(warm_done)
	);

	assign idle_wake = (state == CPMC_IDLE) && irq_hit;

	// next mode from halt, interrupts and the wake pin
	always_comb begin
		next_state = state;
		case (state)
			CPMC_NORMAL: begin
				if (halt_instruction) begin
					next_state = sleep_sel ? CPMC_SLEEP : CPMC_IDLE;
				end
			end
			CPMC_IDLE: begin
				if (irq_hit) begin
					next_state = CPMC_NORMAL;
				end
			end
			CPMC_SLEEP: begin
				if (wake_pin_hit) begin
					next_state = CPMC_WARMUP;
				end
			end
			CPMC_WARMUP: begin
				if (warm_done) begin
					next_state = CPMC_NORMAL;
				end
			end
			default: begin
				next_state = CPMC_NORMAL;
			end
		endcase
		if (full_reset) begin
			next_state = CPMC_NORMAL;
		end
	end

	// mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CPMC_NORMAL;
		end else begin
			state <= next_state;
		end
	end

	// clock enables follow the mode being entered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctrl <= '{osc_en: 1'b1, core_en: 1'b1, periph_en: 1'b1};
		end else begin
			case (next_state)
				CPMC_NORMAL: clk_ctrl <= '{osc_en: 1'b1, core_en: 1'b1, periph_en: 1'b1};
				CPMC_IDLE: clk_ctrl <= '{osc_en: 1'b1, core_en: 1'b0, periph_en: 1'b1};
				CPMC_SLEEP: clk_ctrl <= '{osc_en: 1'b0, core_en: 1'b0, periph_en: 1'b0};
				CPMC_WARMUP: clk_ctrl <= '{osc_en: 1'b1, core_en: 1'b0, periph_en: 1'b0};
				default: clk_ctrl <= '{osc_en: 1'b1, core_en: 1'b1, periph_en: 1'b1};
			endcase
		end
	end

	// resume and vector pulses towards the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_resume <= 1'b0;
			irq_service <= 1'b0;
			sys_reset <= 1'b0;
		end else begin
			sys_reset <= full_reset;
			core_resume <= !full_reset && (idle_wake || (state == CPMC_WARMUP && warm_done));
			irq_service <= !full_reset && global_irq_enable && irq_hit && state == CPMC_NORMAL && !halt_instruction
				|| !full_reset && global_irq_enable && idle_wake;
		end
	end

	assign mode = state;

	// -------------------------------------------------------------------
	// event status and interrupt output
	// -------------------------------------------------------------------
	assign evt_set[CPMC_EVT_IDLE_WAKE] = idle_wake;
	assign evt_set[CPMC_EVT_SLEEP_WAKE] = state == CPMC_WARMUP && warm_done;
	assign evt_set[CPMC_EVT_SLEEP_REQ] = state == CPMC_SLEEP && |src_req;
	assign evt_set[CPMC_EVT_FULL_RESET] = full_reset;

	// sticky events, written one clears, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt <= '0;
		end else begin
			evt <= (evt & ~((wr_en && paddr == CPMC_EVT_ADDR) ? pwdata[CPMC_EVT_W-1:0] : '0)) | evt_set;
		end
	end

	// level interrupt while an unmasked event is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt & evt_mask);
		end
	end

	// -------------------------------------------------------------------
	// apb slave
	// -------------------------------------------------------------------
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign pready = 1'b1;
	assign mapped = paddr == CPMC_MODE_CTRL_ADDR || paddr == CPMC_STATE_ADDR || paddr == CPMC_SRC_EN_ADDR
		|| paddr == CPMC_PEND_ADDR || paddr == CPMC_EVT_ADDR || paddr == CPMC_EVT_MASK_ADDR;
	assign mode_ctrl_rd = (mode_ctrl & CPMC_MODE_CTRL_WMASK) | (8'h01 << CPMC_ONE_BIT);

	// writable control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ctrl <= CPMC_MODE_CTRL_RST;
			src_en <= '0;
			evt_mask <= '0;
		end else if (full_reset) begin
			mode_ctrl <= CPMC_MODE_CTRL_RST;
			src_en <= '0;
			evt_mask <= '0;
		end else if (wr_en) begin
			case (paddr)
				CPMC_MODE_CTRL_ADDR: mode_ctrl <= pwdata[7:0] & CPMC_MODE_CTRL_WMASK;
				CPMC_SRC_EN_ADDR: src_en <= pwdata[SRC_W-1:0];
				CPMC_EVT_MASK_ADDR: evt_mask <= pwdata[CPMC_EVT_W-1:0];
				default: mode_ctrl <= mode_ctrl;
			endcase
		end
	end

	// read data prepared in the setup cycle, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			pslverr <= !mapped;
			case (paddr)
				CPMC_MODE_CTRL_ADDR: prdata <= {24'h00_0000, mode_ctrl_rd};
				CPMC_STATE_ADDR: prdata <= {30'h0000_0000, state};
				CPMC_SRC_EN_ADDR: prdata <= 32'(src_en);
				CPMC_PEND_ADDR: prdata <= 32'(pend);
				CPMC_EVT_ADDR: prdata <= 32'(evt);
				CPMC_EVT_MASK_ADDR: prdata <= 32'(evt_mask);
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_NORMAL && halt_instruction && sleep_sel && !full_reset |=> state == CPMC_SLEEP)
		else $error("halt with sleep select did not enter sleep");

	idle_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_NORMAL && halt_instruction && !sleep_sel && !full_reset |=> state == CPMC_IDLE)
		else $error("halt without sleep select did not enter idle");

	normal_clocks_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_NORMAL |-> clk_ctrl.core_en && clk_ctrl.periph_en && clk_ctrl.osc_en)
		else $error("normal mode clocks not all on");

	idle_clocks_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_IDLE |-> !clk_ctrl.core_en && clk_ctrl.periph_en && clk_ctrl.osc_en)
		else $error("idle mode clocks wrong");

	idle_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_IDLE && irq_hit |=> state == CPMC_NORMAL && clk_ctrl.core_en)
		else $error("enabled interrupt did not wake idle");

	idle_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
		idle_wake && global_irq_enable && !full_reset |=> irq_service && core_resume)
		else $error("idle wake with global enable not serviced");

	idle_novector_a: assert property (@(posedge pclk) disable iff (!presetn)
		idle_wake && !global_irq_enable |=> !irq_service)
		else $error("idle wake without global enable vectored");

	full_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		full_reset |=> state == CPMC_NORMAL && sys_reset && mode_ctrl == CPMC_MODE_CTRL_RST)
		else $error("reset source did not force normal mode");

	sleep_osc_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_SLEEP |-> !clk_ctrl.osc_en && !clk_ctrl.core_en && !clk_ctrl.periph_en)
		else $error("oscillator running in sleep");

	sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_SLEEP && !wake_pin_hit && !full_reset |=> state == CPMC_SLEEP)
		else $error("sleep left without wake pin");

	warmup_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_SLEEP && wake_pin_hit && !full_reset |=> state == CPMC_WARMUP ##1 (state == CPMC_WARMUP || sys_reset))
		else $error("sleep wake skipped warm-up");

	pin_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == CPMC_IDLE && !irq_hit || state == CPMC_NORMAL && !halt_instruction) && !full_reset
		|=> state == $past(state))
		else $error("wake pin acted outside sleep");

	warmup_clocks_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_WARMUP |-> clk_ctrl.osc_en && !clk_ctrl.core_en)
		else $error("warm-up clocks wrong");

	global_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_NORMAL && !global_irq_enable |=> !irq_service)
		else $error("interrupt serviced without global enable");

	sleep_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_SLEEP |=> !irq_service && !core_resume)
		else $error("core woken from sleep by interrupt");

	edge_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == CPMC_NORMAL && halt_instruction && sleep_sel && wake_sens && sleep_wake_pin && !full_reset
		|=> state == CPMC_SLEEP ##1 (state == CPMC_SLEEP || sys_reset))
		else $error("edge sleep not held with pin high");

endmodule // cpmc_top

// File: verification/cpmc_core_model.sv
// core-side partner: acknowledges flags, counts resumes and services
// assumes one-cycle pulses on irq_service and core_resume
`timescale 1ns/1ns
module cpmc_core_model #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// from the controller
	input wire logic irq_service,
	input wire logic core_resume,
	// towards the controller and bench
	output logic [W+1:0] irq_ack,
	output int resumes,
	output int services
);
	// ack all flags after a service or a resume, as software would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= '0;
			resumes <= 0;
			services <= 0;
		end else begin
			irq_ack <= {(W+2){irq_service | core_resume}};
			resumes <= resumes + int'(core_resume);
			services <= services + int'(irq_service);
		end
	end
endmodule // cpmc_core_model

// File: verification/cpmc_top_tb.sv
// self-checking bench of the power mode controller
// assumes an APB slave and a core partner answering on pclk
`timescale 1ns/1ns
module cpmc_top_tb
	import cpmc_pkg::*;
;
	localparam int WU = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic halt, gie, wdt_irq, ext_n, rst_n, wdt_to, pin;
	logic core_resume, irq_service, sys_reset, irq;
	logic [7:0] paddr, periph_irq, ctrl_model;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] irq_ack;
	cpmc_clk_t clk_ctrl;
	cpmc_state_t mode;
	int resumes, services, bad_count, checks, seed, exp_res, exp_srv, n;

	// ----------------------------------------
	// clock, design and partner
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	cpmc_top #(.PERIPH_W(8), .WARMUP(WU)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_instruction(halt), .global_irq_enable(gie), .irq_ack(irq_ack),
		.core_resume(core_resume), .irq_service(irq_service), .periph_irq(periph_irq),
		.wdt_irq(wdt_irq), .ext_irq0_n(ext_n), .reset_pin_n(rst_n), .wdt_timeout(wdt_to),
		.sleep_wake_pin(pin), .clk_ctrl(clk_ctrl), .sys_reset(sys_reset), .mode(mode), .irq(irq));

	cpmc_core_model #(.W(8)) core (.pclk(pclk), .presetn(presetn), .irq_service(irq_service),
		.core_resume(core_resume), .irq_ack(irq_ack), .resumes(resumes), .services(services));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one apb transfer, read data kept in rd and err
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20)
			bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask

	task automatic wait_mode(input cpmc_state_t m, output int cyc);
		cyc = 0;
		do begin
			tick(1);
			cyc++;
		end while (mode !== m && cyc < 200);
		if (cyc >= 200)
			bad_count++;
	endtask

	task automatic halt_cmd();
		@(posedge pclk);
		halt <= 1'b1;
		@(posedge pclk);
		halt <= 1'b0;
	endtask

	// model of mode and clock gating
	task automatic expect_mode(input cpmc_state_t m);
		check(32'(mode), 32'(m), "mode");
		check(32'(clk_ctrl), m == CPMC_NORMAL ? 32'h7 : m == CPMC_IDLE ? 32'h5 : 32'h0, "clocks");
	endtask

	// source 0 random peripheral, 1 watchdog request, 2 external falling edge
	task automatic fire(input int k);
		@(posedge pclk);
		if (k == 0)
			periph_irq <= 8'h1 << ($random(seed) & 7);
		else if (k == 1)
			wdt_irq <= 1'b1;
		else
			ext_n <= 1'b0;
		@(posedge pclk);
		periph_irq <= '0;
		wdt_irq <= 1'b0;
		ext_n <= 1'b1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		complete_run();
	end

	initial begin
		seed = 32'he8329470;
		{presetn, psel, penable, pwrite, halt, gie, wdt_irq, wdt_to, pin} = '0;
		{ext_n, rst_n} = 2'b11;
		paddr = '0;
		pwdata = '0;
		periph_irq = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		expect_mode(CPMC_NORMAL);
		apb(CPMC_MODE_CTRL_ADDR, 1'b0, 32'h0);
		check(rd, 32'h4, "ctrl reset");
		ctrl_model = 8'($random(seed)) | 8'h8c;
		apb(CPMC_MODE_CTRL_ADDR, 1'b1, {24'h0, ctrl_model});
		apb(CPMC_MODE_CTRL_ADDR, 1'b0, 32'h0);
		check(rd, {24'h0, ctrl_model & 8'h73 | 8'h04}, "ctrl rw");
		apb(8'h18, 1'b0, 32'h0);
		check(32'(err), 32'h1, "unmapped");
		apb(CPMC_SRC_EN_ADDR, 1'b1, 32'h3ff);
		// normal mode service only under global enable
		exp_srv = services;
		fire(0);
		tick(5);
		check(services, exp_srv, "no gie");
		@(posedge pclk);
		gie <= 1'b1;
		tick(5);
		check(32'(services > exp_srv), 32'h1, "serviced");
		apb(CPMC_MODE_CTRL_ADDR, 1'b1, 32'h0);
		apb(CPMC_EVT_ADDR, 1'b1, 32'hf);
		// idle entry, pin ignored, wake by each source
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			gie <= k[0];
			halt_cmd();
			wait_mode(CPMC_IDLE, n);
			expect_mode(CPMC_IDLE);
			@(posedge pclk);
			pin <= 1'b1;
			@(posedge pclk);
			pin <= 1'b0;
			tick(4);
			expect_mode(CPMC_IDLE);
			exp_res = resumes + 1;
			exp_srv = services;
			fire(k);
			wait_mode(CPMC_NORMAL, n);
			expect_mode(CPMC_NORMAL);
			tick(4);
			check(resumes, exp_res, "resume");
			check(32'(services > exp_srv), 32'(k[0]), "vector");
		end
		// event mask and write-one-to-clear
		apb(CPMC_EVT_MASK_ADDR, 1'b1, 32'h0);
		tick(2);
		check(32'(irq), 32'h0, "masked");
		apb(CPMC_EVT_MASK_ADDR, 1'b1, 32'h1);
		tick(2);
		check(32'(irq), 32'h1, "unmasked");
		apb(CPMC_EVT_ADDR, 1'b1, 32'h1);
		tick(2);
		check(32'(irq), 32'h0, "cleared");
		// level sleep with pin low beforehand
		@(posedge pclk);
		gie <= 1'b0;
		apb(CPMC_MODE_CTRL_ADDR, 1'b1, 32'h2);
		halt_cmd();
		wait_mode(CPMC_SLEEP, n);
		expect_mode(CPMC_SLEEP);
		fire(0);
		tick(8);
		expect_mode(CPMC_SLEEP);
		apb(CPMC_PEND_ADDR, 1'b0, 32'h0);
		check(32'(rd[7:0] != 8'h0), 32'h1, "recorded");
		exp_res = resumes + 1;
		@(posedge pclk);
		pin <= 1'b1;
		wait_mode(CPMC_WARMUP, n);
		wait_mode(CPMC_NORMAL, n);
		check(n, WU + 1, "warm-up");
		expect_mode(CPMC_NORMAL);
		tick(3);
		check(resumes, exp_res, "sleep resume");
		// request during sleep and sleep wake both recorded
		apb(CPMC_EVT_ADDR, 1'b0, 32'h0);
		check(rd, 32'h6, "sleep events");
		// edge sleep entered with pin high
		apb(CPMC_MODE_CTRL_ADDR, 1'b1, 32'h3);
		halt_cmd();
		wait_mode(CPMC_SLEEP, n);
		expect_mode(CPMC_SLEEP);
		tick(10);
		expect_mode(CPMC_SLEEP);
		@(posedge pclk);
		pin <= 1'b0;
		@(posedge pclk);
		pin <= 1'b1;
		wait_mode(CPMC_NORMAL, n);
		expect_mode(CPMC_NORMAL);
		@(posedge pclk);
		pin <= 1'b0;
		// reset pin and watchdog time-out from idle and sleep
		for (int r = 0; r < 4; r++) begin
			apb(CPMC_MODE_CTRL_ADDR, 1'b1, 32'(r[1]) << 1);
			halt_cmd();
			wait_mode(r[1] ? CPMC_SLEEP : CPMC_IDLE, n);
			@(posedge pclk);
			if (r[0])
				wdt_to <= 1'b1;
			else
				rst_n <= 1'b0;
			tick(2);
			expect_mode(CPMC_NORMAL);
			check(32'(sys_reset), 32'h1, "reset");
			@(posedge pclk);
			wdt_to <= 1'b0;
			rst_n <= 1'b1;
			tick(2);
			apb(CPMC_MODE_CTRL_ADDR, 1'b0, 32'h0);
			check(rd, 32'h4, "ctrl cleared");
		end
		complete_run();
	end
endmodule // cpmc_top_tb
